// ===== logic/dpvc_pkg.sv
// Package of constants and types for the playback path control block
package dpvc_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESERVED_A   = 8'h35;
    localparam logic [7:0] REG_PIN_CTRL     = 8'h36;
    localparam logic [7:0] REG_RESERVED_B   = 8'h37;
    localparam logic [7:0] REG_BLOCK_SEL    = 8'h3c;
    localparam logic [7:0] REG_RESERVED_C   = 8'h3d;
    localparam logic [7:0] REG_PATH_SETUP   = 8'h3f;
    localparam logic [7:0] REG_MUTE_COUPLE  = 8'h40;
    localparam logic [7:0] REG_LEFT_GAIN    = 8'h41;
    localparam logic [7:0] REG_RIGHT_GAIN   = 8'h42;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PIN_MODE_LSB    = 1;
    localparam int PIN_LEVEL_BIT   = 0;
    localparam int PWR_LEFT_BIT    = 7;
    localparam int PWR_RIGHT_BIT   = 6;
    localparam int SRC_LEFT_LSB    = 4;
    localparam int SRC_RIGHT_LSB   = 2;
    localparam int STEP_MODE_LSB   = 0;
    localparam int MUTE_LEFT_BIT   = 3;
    localparam int MUTE_RIGHT_BIT  = 2;
    localparam int COUPLE_LSB      = 0;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_OFF     = 2'b00,
        PIN_ON      = 2'b01,
        PIN_GENERAL = 2'b10,
        PIN_RSVD    = 2'b11
    } dpvc_pin_mode_t;

    typedef enum logic [1:0] {
        SRC_OFF   = 2'b00,
        SRC_SAME  = 2'b01,
        SRC_OTHER = 2'b10,
        SRC_MIX   = 2'b11
    } dpvc_src_t;

    typedef enum logic [1:0] {
        STEP_EVERY = 2'b00,
        STEP_TWO   = 2'b01,
        STEP_NONE  = 2'b10,
        STEP_RSVD  = 2'b11
    } dpvc_step_t;

    typedef enum logic [1:0] {
        CPL_INDEP  = 2'b00,
        CPL_L_OF_R = 2'b01,
        CPL_R_OF_L = 2'b10,
        CPL_INDEP2 = 2'b11
    } dpvc_couple_t;

    // ----------------------------------------------------------------
    // Reset values, block selector range and buffer depth
    // ----------------------------------------------------------------
    localparam logic [1:0] PIN_MODE_RST   = 2'h1;
    localparam logic [4:0] BLOCK_SEL_RST  = 5'h01;
    localparam logic [4:0] BLOCK_SEL_MIN  = 5'h01;
    localparam logic [4:0] BLOCK_SEL_MAX  = 5'h19;
    localparam logic [1:0] SRC_RST        = 2'h1;
    localparam logic [1:0] STEP_RST       = 2'h0;
    localparam logic       MUTE_RST       = 1'h1;
    localparam logic [1:0] COUPLE_RST     = 2'h0;
    localparam logic [7:0] GAIN_RST       = 8'h00;
    localparam logic [1:0] BUF_DEPTH      = 2'h2;

    localparam int SAMPLE_W = 16;

    typedef logic signed [SAMPLE_W-1:0] dpvc_sample_t;

    typedef struct packed {
        dpvc_sample_t left;
        dpvc_sample_t right;
    } dpvc_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wrEn;
        logic       rdEn;
    } dpvc_reg_req_t;

    typedef struct packed {
        logic       pwrLeft;
        logic       pwrRight;
        logic       muteLeft;
        logic       muteRight;
        logic [4:0] blockSel;
        logic       pinEnable;
        logic       pinGeneral;
        logic [7:0] gainLeft;
        logic [7:0] gainRight;
    } dpvc_ctrl_t;

endpackage

// ===== logic/dpvc_top.sv
// Playback path control registers, routing, mute and gain stepping
`timescale 1ns/10ps
//
// Function
// - Pin mode 00 off, 01 interface, 10 general input; read bit shows level, reads zero in mode 00.
// - Five-bit block selector, codes 1 to 25, reset to block one; writes store any five-bit code.
// - Setup bit 7 powers left channel up; reset powered down.
// - Setup bit 6 powers right channel up; reset powered down.
// - Left source off, left, right, or (L+R)/2; reset left.
// - Right source off, right, left, or (L+R)/2; reset right.
// - Stepping each sample, each two samples, or none; 11 not written, though a written 11 is stored and holds the applied gain.
// - Volume bit 3 mutes left channel; reset muted.
// - Volume bit 2 mutes right channel; reset muted.
// - Coupling 00/11 independent, 01 left follows right, 10 right follows left.
// - Compressor active forces independent gains; software programs coupling zero.
// - Left gain is two's-complement half-decibel steps, reset zero.
// - Right gain register, same encoding, reset zero.
module dpvc_top
    import dpvc_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Register port
    input  wire dpvc_reg_req_t regReq,
    output logic [7:0]         regRdata,
    // Pins and status
    input  wire logic          serialInPin,
    input  wire logic          compressorActive,
    // Sample input
    input  wire dpvc_frame_t   inFrame,
    input  wire logic          inValid,
    output logic               inReady,
    // Sample output
    output dpvc_frame_t        outFrame,
    output logic               outValid,
    input  wire logic          outReady,
    // Control to the converter
    output dpvc_ctrl_t         ctrl
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rstSync_r;
    logic       rstSyncN;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    // Only the second stage feeds the design's reset
    assign rstSyncN = rstSync_r[1];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  pinMode;
        logic        pinEnable;
        logic        pinGeneral;
        logic [4:0]  blockSel;
        logic        pwrLeft;
        logic        pwrRight;
        logic [1:0]  srcLeft;
        logic [1:0]  srcRight;
        logic [1:0]  stepMode;
        logic        muteLeft;
        logic        muteRight;
        logic [1:0]  couple;
        logic [7:0]  gainLeft;
        logic [7:0]  gainRight;
        logic [7:0]  appLeft;
        logic [7:0]  appRight;
        logic        stepPhase;
        logic [7:0]  rdata;
        dpvc_frame_t buf0;
        dpvc_frame_t buf1;
        logic [1:0]  count;
        logic        inReady;
        logic        outValid;
    } dpvc_state_t;

    dpvc_state_t state_r;
    dpvc_state_t state_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] stepToward(input logic [7:0] cur, input logic [7:0] tgt);
        if ($signed(cur) < $signed(tgt)) begin
            stepToward = cur + 8'h01;
        end else if ($signed(cur) > $signed(tgt)) begin
            stepToward = cur - 8'h01;
        end else begin
            stepToward = cur;
        end
    endfunction

    function automatic dpvc_sample_t routeSample(input logic [1:0] src,
                                                 input dpvc_sample_t same,
                                                 input dpvc_sample_t other,
                                                 input logic mute);
        logic signed [SAMPLE_W:0] sum;
        sum = {same[SAMPLE_W-1], same} + {other[SAMPLE_W-1], other};
        case (src)
            SRC_OFF:   routeSample = '0;
            SRC_SAME:  routeSample = same;
            SRC_OTHER: routeSample = other;
            SRC_MIX:   routeSample = sum[SAMPLE_W:1];
            default:   routeSample = '0;
        endcase
        if (mute) begin
            routeSample = '0;
        end
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic        accept;
    logic        pop;
    logic        stepNow;
    logic [7:0]  tgtLeft;
    logic [7:0]  tgtRight;
    dpvc_frame_t routed;
    logic        pinLevel;

    always_comb begin
        state_nxt = state_r;
        accept    = inValid && state_r.inReady;
        pop       = state_r.outValid && outReady;
        pinLevel  = (state_r.pinMode == PIN_OFF) ? 1'b0 : serialInPin;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (regReq.wrEn) begin
            case (regReq.addr)
                REG_PIN_CTRL:    state_nxt.pinMode = regReq.wdata[PIN_MODE_LSB +: 2];
                REG_BLOCK_SEL:   state_nxt.blockSel = regReq.wdata[4:0];
                REG_PATH_SETUP: begin
                    state_nxt.pwrLeft  = regReq.wdata[PWR_LEFT_BIT];
                    state_nxt.pwrRight = regReq.wdata[PWR_RIGHT_BIT];
                    state_nxt.srcLeft  = regReq.wdata[SRC_LEFT_LSB +: 2];
                    state_nxt.srcRight = regReq.wdata[SRC_RIGHT_LSB +: 2];
                    state_nxt.stepMode = regReq.wdata[STEP_MODE_LSB +: 2];
                end
                REG_MUTE_COUPLE: begin
                    state_nxt.muteLeft  = regReq.wdata[MUTE_LEFT_BIT];
                    state_nxt.muteRight = regReq.wdata[MUTE_RIGHT_BIT];
                    state_nxt.couple    = regReq.wdata[COUPLE_LSB +: 2];
                end
                REG_LEFT_GAIN:   state_nxt.gainLeft = regReq.wdata;
                REG_RIGHT_GAIN:  state_nxt.gainRight = regReq.wdata;
                default:         ; // Reserved offsets keep nothing
            endcase
        end

        // ------------------------------------------------------------
        // Pin use decode
        // ------------------------------------------------------------
        // Registered so that the control outputs come from flops
        state_nxt.pinEnable  = (state_nxt.pinMode == PIN_ON);
        state_nxt.pinGeneral = (state_nxt.pinMode == PIN_GENERAL);

        // ------------------------------------------------------------
        // Register reads, one cycle latency
        // ------------------------------------------------------------
        if (regReq.rdEn) begin
            case (regReq.addr)
                REG_PIN_CTRL:    state_nxt.rdata = {5'h00, state_r.pinMode, pinLevel};
                REG_BLOCK_SEL:   state_nxt.rdata = {3'h0, state_r.blockSel};
                REG_PATH_SETUP:  state_nxt.rdata = {state_r.pwrLeft, state_r.pwrRight,
                                                    state_r.srcLeft, state_r.srcRight,
                                                    state_r.stepMode};
                REG_MUTE_COUPLE: state_nxt.rdata = {4'h0, state_r.muteLeft,
                                                    state_r.muteRight, state_r.couple};
                REG_LEFT_GAIN:   state_nxt.rdata = state_r.gainLeft;
                REG_RIGHT_GAIN:  state_nxt.rdata = state_r.gainRight;
                default:         state_nxt.rdata = 8'h00;
            endcase
        end

        // ------------------------------------------------------------
        // Gain targets with coupling
        // ------------------------------------------------------------
        tgtLeft  = state_r.gainLeft;
        tgtRight = state_r.gainRight;
        if (!compressorActive) begin
            if (state_r.couple == CPL_L_OF_R) begin
                tgtLeft = state_r.gainRight;
            end else if (state_r.couple == CPL_R_OF_L) begin
                tgtRight = state_r.gainLeft;
            end
        end

        // ------------------------------------------------------------
        // Gain stepping, one sample period per accepted frame
        // ------------------------------------------------------------
        stepNow = 1'b0;
        case (state_r.stepMode)
            STEP_EVERY: stepNow = accept;
            STEP_TWO: begin
                if (accept) begin
                    state_nxt.stepPhase = !state_r.stepPhase;
                    stepNow = state_r.stepPhase;
                end
            end
            // Reserved code holds the applied gain
            default:    stepNow = 1'b0;
        endcase
        if (state_r.stepMode == STEP_NONE) begin
            state_nxt.appLeft  = tgtLeft;
            state_nxt.appRight = tgtRight;
        end else if (stepNow) begin
            state_nxt.appLeft  = stepToward(state_r.appLeft, tgtLeft);
            state_nxt.appRight = stepToward(state_r.appRight, tgtRight);
        end

        // ------------------------------------------------------------
        // Routing and mute
        // ------------------------------------------------------------
        // Powered-down channel sends silence like a muted one
        routed.left  = routeSample(state_r.srcLeft, inFrame.left, inFrame.right,
                                   state_r.muteLeft || !state_r.pwrLeft);
        routed.right = routeSample(state_r.srcRight, inFrame.right, inFrame.left,
                                   state_r.muteRight || !state_r.pwrRight);

        // ------------------------------------------------------------
        // Two-entry buffer
        // ------------------------------------------------------------
        // Head moves up on a pop; a new frame fills the first free place
        if (pop) begin
            state_nxt.buf0 = state_r.buf1;
        end
        if (accept) begin
            if ((state_r.count == 2'h0) || (pop && state_r.count == 2'h1)) begin
                state_nxt.buf0 = routed;
            end else begin
                state_nxt.buf1 = routed;
            end
        end
        case ({accept, pop})
            2'b10:   state_nxt.count = state_r.count + 2'h1;
            2'b01:   state_nxt.count = state_r.count - 2'h1;
            default: state_nxt.count = state_r.count;
        endcase
        state_nxt.inReady  = (state_nxt.count != BUF_DEPTH);
        state_nxt.outValid = (state_nxt.count != 2'h0);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r           <= '0;
            state_r.pinMode   <= PIN_MODE_RST;
            state_r.pinEnable <= (PIN_MODE_RST == PIN_ON);
            state_r.pinGeneral <= (PIN_MODE_RST == PIN_GENERAL);
            state_r.blockSel  <= BLOCK_SEL_RST;
            state_r.srcLeft   <= SRC_RST;
            state_r.srcRight  <= SRC_RST;
            state_r.stepMode  <= STEP_RST;
            state_r.muteLeft  <= MUTE_RST;
            state_r.muteRight <= MUTE_RST;
            state_r.couple    <= COUPLE_RST;
            state_r.gainLeft  <= GAIN_RST;
            state_r.gainRight <= GAIN_RST;
            state_r.appLeft   <= GAIN_RST;
            state_r.appRight  <= GAIN_RST;
            state_r.inReady   <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign regRdata       = state_r.rdata;
    assign inReady        = state_r.inReady;
    assign outValid       = state_r.outValid;
    assign outFrame       = state_r.buf0;
    assign ctrl = '{
        pwrLeft:    state_r.pwrLeft,
        pwrRight:   state_r.pwrRight,
        muteLeft:   state_r.muteLeft,
        muteRight:  state_r.muteRight,
        blockSel:   state_r.blockSel,
        pinEnable:  state_r.pinEnable,
        pinGeneral: state_r.pinGeneral,
        gainLeft:   state_r.appLeft,
        gainRight:  state_r.appRight
    };

endmodule // dpvc_top

// ===== tb/dpvc_checker.sv
// Concurrent checks on the ports of the playback path control block
`timescale 1ns/10ps
module dpvc_checker
    import dpvc_pkg::*;
(
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // Register port
    input wire dpvc_reg_req_t regReq,
    input wire logic [7:0]    regRdata,
    // Stream
    input wire logic          inValid,
    input wire logic          inReady,
    input wire logic          outValid,
    input wire dpvc_frame_t   outFrame,
    input wire logic          outReady,
    // Control
    input wire dpvc_ctrl_t    ctrl
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Stream handshake
    // ------------------------------------------------------------
    sequence s_accept; inValid && inReady; endsequence
    sequence s_stall; outValid && !outReady; endsequence
    sequence s_drain; outValid && outReady; endsequence

    a_stall_holds: assert property (s_stall |=> outValid && $stable(outFrame))
        else $error("output frame changed while stalled");
    a_accept_out: assert property (s_accept |=> outValid)
        else $error("accepted frame did not appear");
    a_full_valid: assert property (!inReady |-> outValid)
        else $error("buffer refuses while empty");
    a_drain_room: assert property (s_drain |=> inReady)
        else $error("no room after a drain");

    // ------------------------------------------------------------
    // Registers and control
    // ------------------------------------------------------------
    sequence s_setup_wr; regReq.wrEn && regReq.addr == REG_PATH_SETUP; endsequence
    sequence s_mute_wr; regReq.wrEn && regReq.addr == REG_MUTE_COUPLE; endsequence
    sequence s_pin_wr; regReq.wrEn && regReq.addr == REG_PIN_CTRL; endsequence

    a_rsvd_zero: assert property (
        regReq.rdEn && regReq.addr == REG_RESERVED_B |=> regRdata == 8'h00)
        else $error("reserved register read nonzero");
    a_blk_upper: assert property (
        regReq.rdEn && regReq.addr == REG_BLOCK_SEL |=> regRdata[7:5] == 3'h0)
        else $error("block select upper bits set");
    a_mute_upper: assert property (
        regReq.rdEn && regReq.addr == REG_MUTE_COUPLE |=> regRdata[7:4] == 4'h0)
        else $error("mute register upper bits set");
    a_pwr_left: assert property (
        s_setup_wr |=> ctrl.pwrLeft == $past(regReq.wdata[PWR_LEFT_BIT]))
        else $error("left power bit not applied");
    a_mute_clear: assert property (
        s_mute_wr ##0 !regReq.wdata[MUTE_LEFT_BIT] |=> !ctrl.muteLeft)
        else $error("left mute not cleared");
    a_pin_decode: assert property (
        s_pin_wr |=> ctrl.pinEnable == ($past(regReq.wdata[PIN_MODE_LSB +: 2]) == PIN_ON)
            && ctrl.pinGeneral == ($past(regReq.wdata[PIN_MODE_LSB +: 2]) == PIN_GENERAL))
        else $error("pin use decoded wrongly");
endmodule // dpvc_checker

bind dpvc_top dpvc_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .inValid(inValid), .inReady(inReady), .outValid(outValid),
    .outFrame(outFrame), .outReady(outReady), .ctrl(ctrl));

// ===== tb/dac_path_volume_control_test.sv
// Self-checking testbench of the playback path control block
`timescale 1ns/10ps
module dac_path_volume_control_test;
    import dpvc_pkg::*;
    logic          sys_clk, rst_n, serialInPin, compressorActive, inValid, inReady;
    logic          outValid, outReady;
    dpvc_reg_req_t regReq;
    logic [7:0]    regRdata, d;
    dpvc_frame_t   inFrame, outFrame, f;
    dpvc_ctrl_t    ctrl;
    int            errCount, numChecks;
    logic [15:0]   expL [4] = '{16'h0000, 16'h0064, 16'hffce, 16'h0019};
    logic [15:0]   expR [4] = '{16'h0000, 16'hffce, 16'h0064, 16'h0019};

    dpvc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
        .serialInPin(serialInPin), .compressorActive(compressorActive), .inFrame(inFrame),
        .inValid(inValid), .inReady(inReady), .outFrame(outFrame), .outValid(outValid),
        .outReady(outReady), .ctrl(ctrl));

    // ------------------------------------------------------------
    // Clock, access tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        regReq = '{addr: a, wdata: v, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge sys_clk);
        #1 regReq.wrEn = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        regReq = '{addr: a, wdata: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge sys_clk);
        #1 regReq.rdEn = 1'b0;
        @(posedge sys_clk);
        #1 chk(regRdata, exp);
    endtask

    task automatic push(input logic [15:0] l, input logic [15:0] r);
        int n;
        n = 0;
        inFrame = {l, r};
        inValid = 1'b1;
        while (inReady !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        @(posedge sys_clk);
        #1 inValid = 1'b0;
        if (n >= 50) chk(1'b0, 1'b1);
    endtask

    task automatic pop(output dpvc_frame_t fr);
        int n;
        n = 0;
        while (!(outValid === 1'b1 && outReady === 1'b1) && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        fr = outFrame;
        if (n >= 50) chk(1'b0, 1'b1);
        @(posedge sys_clk);
        #1;
    endtask

    task automatic xfer(input logic [15:0] l, input logic [15:0] r);
        push(l, r);
        pop(f);
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", errCount, numChecks);
        if (errCount == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errCount++;
        close_out();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [1:0] m;
        errCount = 0;
        numChecks = 0;
        rst_n = 1'b0;
        regReq = '0;
        serialInPin = 1'b1;
        compressorActive = 1'b0;
        inFrame = '0;
        inValid = 1'b0;
        outReady = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        // Reset values
        rreg(REG_RESERVED_A, 8'h00);
        rreg(REG_PIN_CTRL, 8'h03);
        rreg(REG_BLOCK_SEL, 8'h01);
        rreg(REG_PATH_SETUP, 8'h14);
        rreg(REG_MUTE_COUPLE, 8'h0c);
        rreg(REG_LEFT_GAIN, 8'h00);
        rreg(REG_RIGHT_GAIN, 8'h00);
        chk({ctrl.muteLeft, ctrl.muteRight, ctrl.pwrLeft, ctrl.pwrRight,
             ctrl.pinEnable, ctrl.pinGeneral}, 6'h32);
        // Pin modes; level hidden while the pin is off
        wreg(REG_PIN_CTRL, 8'h00);
        rreg(REG_PIN_CTRL, 8'h00);
        chk({ctrl.pinEnable, ctrl.pinGeneral}, 2'b00);
        wreg(REG_PIN_CTRL, 8'h04);
        rreg(REG_PIN_CTRL, 8'h05);
        chk({ctrl.pinEnable, ctrl.pinGeneral}, 2'b01);
        wreg(REG_PIN_CTRL, 8'hfa);
        serialInPin = 1'b0;
        rreg(REG_PIN_CTRL, 8'h02);
        chk({ctrl.pinEnable, ctrl.pinGeneral}, 2'b10);
        // Block select, reserved places
        wreg(REG_BLOCK_SEL, 8'h19);
        rreg(REG_BLOCK_SEL, 8'h19);
        chk(ctrl.blockSel, 5'h19);
        rreg(REG_RESERVED_B, 8'h00);
        rreg(REG_RESERVED_C, 8'h00);
        wreg(REG_MUTE_COUPLE, 8'h00);
        rreg(REG_MUTE_COUPLE, 8'h00);
        // Routing modes, then mutes and right power-down, no stepping
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wreg(REG_PATH_SETUP, {2'b11, m, m, 2'b10});
            xfer(16'h0064, 16'hffce);
            chk(f, {expL[i], expR[i]});
        end
        wreg(REG_PATH_SETUP, 8'hd6);
        wreg(REG_MUTE_COUPLE, 8'h08);
        xfer(16'h0064, 16'hffce);
        chk(f, 32'h0000ffce);
        wreg(REG_MUTE_COUPLE, 8'h04);
        xfer(16'h0064, 16'hffce);
        chk(f, 32'h00640000);
        wreg(REG_MUTE_COUPLE, 8'h00);
        wreg(REG_PATH_SETUP, 8'h96);
        xfer(16'h0064, 16'hffce);
        chk(f, 32'h00640000);
        // Gain and coupling, stepping off
        wreg(REG_LEFT_GAIN, 8'h30);
        repeat (2) @(posedge sys_clk);
        #1 chk(ctrl.gainLeft, 8'h30);
        wreg(REG_MUTE_COUPLE, 8'h01);
        wreg(REG_RIGHT_GAIN, 8'h81);
        repeat (2) @(posedge sys_clk);
        #1 chk({ctrl.gainLeft, ctrl.gainRight}, 16'h8181);
        compressorActive = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk({ctrl.gainLeft, ctrl.gainRight}, 16'h3081);
        compressorActive = 1'b0;
        wreg(REG_MUTE_COUPLE, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1 chk({ctrl.gainLeft, ctrl.gainRight}, 16'h3030);
        wreg(REG_MUTE_COUPLE, 8'h03);
        repeat (2) @(posedge sys_clk);
        #1 chk({ctrl.gainLeft, ctrl.gainRight}, 16'h3081);
        wreg(REG_MUTE_COUPLE, 8'h00);
        // Soft stepping per frame and per two frames
        wreg(REG_PATH_SETUP, 8'hd4);
        wreg(REG_LEFT_GAIN, 8'h2e);
        xfer(16'h0001, 16'h0002);
        chk(ctrl.gainLeft, 8'h2f);
        xfer(16'h0001, 16'h0002);
        chk(ctrl.gainLeft, 8'h2e);
        wreg(REG_PATH_SETUP, 8'hd5);
        wreg(REG_LEFT_GAIN, 8'h2c);
        repeat (2) xfer(16'h0001, 16'h0002);
        chk(ctrl.gainLeft, 8'h2d);
        repeat (2) xfer(16'h0001, 16'h0002);
        chk(ctrl.gainLeft, 8'h2c);
        // Two-entry buffer under a stalled receiver
        wreg(REG_PATH_SETUP, 8'hd6);
        outReady = 1'b0;
        push(16'h1111, 16'h2222);
        @(posedge sys_clk);
        #1;
        push(16'h3333, 16'h4444);
        chk({inReady, outValid}, 2'b01);
        outReady = 1'b1;
        pop(f);
        chk(f, 32'h11112222);
        pop(f);
        chk(f, 32'h33334444);
        close_out();
    end
endmodule // dac_path_volume_control_test
